/* File: cpu_status_flag_pkg.sv */
// Package with flag positions, register offsets, reset values and operation codes of the status flag logic.
package cpu_status_flag_pkg;
   localparam logic [3:0] FLAGS_OFFSET = 4'h0;
   localparam logic [3:0] CTRL_OFFSET = 4'h1;
   localparam logic [3:0] LAST_OP_OFFSET = 4'h2;
   localparam int CARRY_POS = 7;
   localparam int ZERO_POS = 6;
   localparam int SIGN_POS = 5;
   localparam int OVFL_POS = 4;
   localparam int DEC_POS = 3;
   localparam int HALF_POS = 2;
   localparam int QUICK_POS = 1;
   localparam int PAGE_POS = 0;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] SHADOW_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h01;

   typedef enum logic [4:0] {
      OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CMP, OP_INC, OP_DEC,
      OP_AND, OP_OR, OP_XOR, OP_COM, OP_TEST,
      OP_RL, OP_RLC, OP_RR, OP_RRC, OP_SRA,
      OP_CARRY_ONE, OP_CARRY_ZERO, OP_CARRY_INV, OP_PAGE_ZERO, OP_PAGE_ONE,
      OP_QUICK_ENTER, OP_IRQ_RETURN, OP_DEC_ADJ
   } op_t;

   typedef struct packed {
      op_t op;
      logic [7:0] dst;
      logic [7:0] src;
   } exec_req_t;

   typedef struct packed {
      logic carry;
      logic zero;
      logic sign;
      logic ovfl;
      logic decSub;
      logic half;
      logic quickIrq;
      logic page;
   } flags_t;
endpackage

/* File: cpu_status_flag_logic.sv */
// Status flag register and flag update datapath of an 8-bit CPU core.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module cpu_status_flag_logic
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic execValid,
   input wire cpu_status_flag_pkg::exec_req_t execReq,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   output cpu_status_flag_pkg::flags_t flags,
   output logic [7:0] result,
   output logic quickReturn,
   output logic irqBlocked
);
   cpu_status_flag_pkg::flags_t next_flags;
   cpu_status_flag_pkg::flags_t shadow;
   logic [7:0] next_result;
   logic [7:0] ctrl;
   logic [4:0] lastOp;
   logic [8:0] sum;
   logic [4:0] lowSum;
   logic isArith;
   logic isSub;
   logic isLogic;
   logic isShift;
   logic flagWrite;

   // Address decode used by both the write and the read path.
   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = (a == off);
   endfunction

   assign flagWrite = regWrite && hit(regAddr, cpu_status_flag_pkg::FLAGS_OFFSET);

   // Combinational flag and result computation for the operation in flight.
   always_comb
   begin
      next_flags = flags;
      next_result = execReq.dst;
      isArith = 1'b0;
      isSub = 1'b0;
      isLogic = 1'b0;
      isShift = 1'b0;
      sum = 9'h000;
      lowSum = 5'h00;
      case (execReq.op)
         cpu_status_flag_pkg::OP_ADD, cpu_status_flag_pkg::OP_ADC:
         begin
            isArith = 1'b1;
            sum = {1'b0, execReq.dst} + {1'b0, execReq.src}
               + {8'h00, (execReq.op == cpu_status_flag_pkg::OP_ADC) & flags.carry};
            lowSum = {1'b0, execReq.dst[3:0]} + {1'b0, execReq.src[3:0]}
               + {4'h0, (execReq.op == cpu_status_flag_pkg::OP_ADC) & flags.carry};
         end
         cpu_status_flag_pkg::OP_SUB, cpu_status_flag_pkg::OP_SBC, cpu_status_flag_pkg::OP_CMP:
         begin
            isArith = 1'b1;
            isSub = 1'b1;
            sum = {1'b0, execReq.dst} - {1'b0, execReq.src}
               - {8'h00, (execReq.op == cpu_status_flag_pkg::OP_SBC) & flags.carry};
            lowSum = {1'b0, execReq.dst[3:0]} - {1'b0, execReq.src[3:0]}
               - {4'h0, (execReq.op == cpu_status_flag_pkg::OP_SBC) & flags.carry};
         end
         cpu_status_flag_pkg::OP_INC:
         begin
            sum = {1'b0, execReq.dst} + 9'h001;
            next_flags.ovfl = (execReq.dst == 8'h7f);
         end
         cpu_status_flag_pkg::OP_DEC:
         begin
            sum = {1'b0, execReq.dst} - 9'h001;
            next_flags.ovfl = (execReq.dst == 8'h80);
         end
         cpu_status_flag_pkg::OP_AND, cpu_status_flag_pkg::OP_TEST:
         begin
            isLogic = 1'b1;
            sum = {1'b0, execReq.dst & execReq.src};
         end
         cpu_status_flag_pkg::OP_OR:
         begin
            isLogic = 1'b1;
            sum = {1'b0, execReq.dst | execReq.src};
         end
         cpu_status_flag_pkg::OP_XOR:
         begin
            isLogic = 1'b1;
            sum = {1'b0, execReq.dst ^ execReq.src};
         end
         cpu_status_flag_pkg::OP_COM:
         begin
            isLogic = 1'b1;
            sum = {1'b0, ~execReq.dst};
         end
         cpu_status_flag_pkg::OP_RL, cpu_status_flag_pkg::OP_RLC:
         begin
            isShift = 1'b1;
            sum = {execReq.dst[7], execReq.dst[6:0],
               (execReq.op == cpu_status_flag_pkg::OP_RLC) ? flags.carry : execReq.dst[7]};
         end
         cpu_status_flag_pkg::OP_RR:
         begin
            isShift = 1'b1;
            sum = {execReq.dst[0], execReq.dst[0], execReq.dst[7:1]};
         end
         cpu_status_flag_pkg::OP_RRC:
         begin
            isShift = 1'b1;
            sum = {execReq.dst[0], flags.carry, execReq.dst[7:1]};
         end
         cpu_status_flag_pkg::OP_SRA:
         begin
            isShift = 1'b1;
            sum = {execReq.dst[0], execReq.dst[7], execReq.dst[7:1]};
         end
         cpu_status_flag_pkg::OP_DEC_ADJ:
         begin
            // Correction uses the stored half carry, carry and direction bits.
            sum = {1'b0, execReq.dst};
            if (flags.decSub)
            begin
               if (flags.half)
               begin
                  sum = sum - 9'h006;
               end
               if (flags.carry)
               begin
                  sum = sum - 9'h060;
               end
               sum[8] = flags.carry;
            end
            else
            begin
               if (flags.half || (execReq.dst[3:0] > 4'h9))
               begin
                  sum = sum + 9'h006;
               end
               if (flags.carry || (sum[7:0] > 8'h99) || sum[8])
               begin
                  sum = {1'b1, sum[7:0] + 8'h60};
               end
            end
            next_flags.carry = sum[8];
         end
         cpu_status_flag_pkg::OP_CARRY_ONE: next_flags.carry = 1'b1;
         cpu_status_flag_pkg::OP_CARRY_ZERO: next_flags.carry = 1'b0;
         cpu_status_flag_pkg::OP_CARRY_INV: next_flags.carry = ~flags.carry;
         cpu_status_flag_pkg::OP_PAGE_ZERO: next_flags.page = 1'b0;
         cpu_status_flag_pkg::OP_PAGE_ONE: next_flags.page = 1'b1;
         cpu_status_flag_pkg::OP_QUICK_ENTER: next_flags.quickIrq = 1'b1;
         cpu_status_flag_pkg::OP_IRQ_RETURN:
         begin
            // A quick return restores the saved copy, with its active bit cleared.
            if (flags.quickIrq)
            begin
               next_flags = shadow;
               next_flags.quickIrq = 1'b0;
            end
         end
         default: next_flags = flags;
      endcase
      if (execReq.op inside {cpu_status_flag_pkg::OP_ADD, cpu_status_flag_pkg::OP_ADC,
         cpu_status_flag_pkg::OP_SUB, cpu_status_flag_pkg::OP_SBC, cpu_status_flag_pkg::OP_CMP,
         cpu_status_flag_pkg::OP_INC, cpu_status_flag_pkg::OP_DEC, cpu_status_flag_pkg::OP_DEC_ADJ})
      begin
         next_result = sum[7:0];
         next_flags.zero = (sum[7:0] == 8'h00);
         next_flags.sign = sum[7];
      end
      if (isArith)
      begin
         next_flags.carry = sum[8];
         next_flags.half = lowSum[4];
         next_flags.decSub = isSub;
         next_flags.ovfl = isSub ? ((execReq.dst[7] != execReq.src[7]) && (sum[7] != execReq.dst[7]))
            : ((execReq.dst[7] == execReq.src[7]) && (sum[7] != execReq.dst[7]));
      end
      if (isLogic)
      begin
         next_result = sum[7:0];
         next_flags.zero = (sum[7:0] == 8'h00);
         next_flags.sign = sum[7];
         next_flags.ovfl = 1'b0;
      end
      if (isShift)
      begin
         next_result = sum[7:0];
         next_flags.carry = sum[8];
         next_flags.zero = (sum[7:0] == 8'h00);
         next_flags.sign = sum[7];
         next_flags.ovfl = execReq.dst[7] ^ sum[7];
      end
      if (execReq.op == cpu_status_flag_pkg::OP_CMP || execReq.op == cpu_status_flag_pkg::OP_TEST)
      begin
         next_result = execReq.dst;
      end
   end

   // Status register; a direct write takes effect only when no update competes, so in a collision the update wins and the write is lost.
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         flags <= cpu_status_flag_pkg::FLAGS_RESET;
      end
      else if (clkEn)
      begin
         if (execValid)
         begin
            flags <= next_flags;
         end
         else if (flagWrite)
         begin
            flags <= regWdata;
         end
      end
   end

   // Saved copy taken on quick interrupt entry.
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         shadow <= cpu_status_flag_pkg::SHADOW_RESET;
      end
      else if (clkEn && execValid && execReq.op == cpu_status_flag_pkg::OP_QUICK_ENTER)
      begin
         shadow <= flags;
      end
   end

   // Result, quick return strobe and interrupt block output.
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         result <= 8'h00;
         quickReturn <= 1'b0;
         irqBlocked <= 1'b0;
         lastOp <= 5'h00;
      end
      else if (clkEn)
      begin
         quickReturn <= execValid && execReq.op == cpu_status_flag_pkg::OP_IRQ_RETURN && flags.quickIrq;
         irqBlocked <= execValid ? next_flags.quickIrq : (flagWrite ? regWdata[cpu_status_flag_pkg::QUICK_POS]
            : flags.quickIrq);
         if (execValid)
         begin
            result <= next_result;
            lastOp <= execReq.op;
         end
      end
   end

   // Spare control byte kept as software scratch; it steers no logic, so writes to it are harmless.
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl <= cpu_status_flag_pkg::CTRL_RESET;
      end
      else if (clkEn && regWrite && hit(regAddr, cpu_status_flag_pkg::CTRL_OFFSET))
      begin
         ctrl <= regWdata;
      end
   end

   // Read data appear one enabled cycle after the strobe and stay until the next enabled edge.
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         regRdata <= 8'h00;
      end
      else if (clkEn)
      begin
         regRdata <= 8'h00;
         if (regRead)
         begin
            if (hit(regAddr, cpu_status_flag_pkg::FLAGS_OFFSET))
            begin
               regRdata <= flags;
            end
            else if (hit(regAddr, cpu_status_flag_pkg::CTRL_OFFSET))
            begin
               regRdata <= ctrl;
            end
            else if (hit(regAddr, cpu_status_flag_pkg::LAST_OP_OFFSET))
            begin
               regRdata <= {3'h0, lastOp};
            end
         end
      end
   end

   sequence s_quick_enter;
      execValid && clkEn && execReq.op == cpu_status_flag_pkg::OP_QUICK_ENTER;
   endsequence
   sequence s_quick_exit;
      execValid && clkEn && execReq.op == cpu_status_flag_pkg::OP_IRQ_RETURN && flags.quickIrq;
   endsequence
   a_quick_enter_sets: assert property (@(posedge core_clk) disable iff (!nrst)
      s_quick_enter |=> flags.quickIrq ##1 irqBlocked)
      else $error("Quick interrupt entry did not set the active bit.");
   a_quick_exit_clears: assert property (@(posedge core_clk) disable iff (!nrst)
      s_quick_exit |=> !flags.quickIrq && quickReturn && flags[7:2] == $past(shadow[7:2]))
      else $error("Quick return did not restore flags.");
   a_carry_force_one: assert property (@(posedge core_clk) disable iff (!nrst)
      execValid && clkEn && execReq.op == cpu_status_flag_pkg::OP_CARRY_ONE
      |=> flags.carry && flags[6:0] == $past(flags[6:0]))
      else $error("Carry force one failed.");
   a_carry_invert: assert property (@(posedge core_clk) disable iff (!nrst)
      execValid && clkEn && execReq.op == cpu_status_flag_pkg::OP_CARRY_INV
      |=> flags.carry != $past(flags.carry))
      else $error("Carry invert failed.");
   a_page_select: assert property (@(posedge core_clk) disable iff (!nrst)
      execValid && clkEn && execReq.op inside {cpu_status_flag_pkg::OP_PAGE_ZERO, cpu_status_flag_pkg::OP_PAGE_ONE}
      |=> flags.page == ($past(execReq.op) == cpu_status_flag_pkg::OP_PAGE_ONE))
      else $error("Page select bit wrong.");
   a_add_carry_zero: assert property (@(posedge core_clk) disable iff (!nrst)
      execValid && clkEn && execReq.op == cpu_status_flag_pkg::OP_ADD
      |=> flags.carry == ({1'b0, $past(execReq.dst)} + {1'b0, $past(execReq.src)} > 9'h0ff)
      && result == 8'($past(execReq.dst) + $past(execReq.src))
      && flags.zero == (result == 8'h00) && flags.sign == result[7])
      else $error("Add flags wrong.");
   a_logic_clears_ovfl: assert property (@(posedge core_clk) disable iff (!nrst)
      execValid && clkEn && execReq.op == cpu_status_flag_pkg::OP_AND
      |=> !flags.ovfl && result == ($past(execReq.dst) & $past(execReq.src)))
      else $error("Logic operation left overflow set.");
   a_shift_carry_out: assert property (@(posedge core_clk) disable iff (!nrst)
      execValid && clkEn && execReq.op == cpu_status_flag_pkg::OP_RL
      |=> flags.carry == $past(execReq.dst[7]) && flags.zero == (result == 8'h00))
      else $error("Rotate carry wrong.");
   a_direct_write: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && flagWrite && !execValid |=> flags == $past(regWdata))
      else $error("Direct write to status lost.");
   a_read_delay: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && regRead && hit(regAddr, cpu_status_flag_pkg::FLAGS_OFFSET) && !execValid && !regWrite
      |=> regRdata == $past(flags))
      else $error("Status read data wrong.");
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking testbench of the status flag register and its update datapath.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin errors++; $display("FAIL %s expected %h seen %h", nm, e, g); end end
module tb_top;
   typedef struct {
      cpu_status_flag_pkg::op_t op;
      logic [7:0] pre, dst, src, expF, maskF, expR, maskR;
   } row_t;
   row_t rows[$];
   int errors = 0;
   int nCompared = 0;
   int cycles = 0;
   logic core_clk = 1'h0;
   logic nrst = 1'h0;
   logic clkEn = 1'h1;
   logic execValid = 1'h0;
   cpu_status_flag_pkg::exec_req_t execReq = '0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWdata = 8'h00;
   logic regWrite = 1'h0;
   logic regRead = 1'h0;
   logic [7:0] regRdata;
   cpu_status_flag_pkg::flags_t flags;
   logic [7:0] result;
   logic quickReturn;
   logic irqBlocked;
   logic [7:0] flagVec;
   logic [7:0] d;
   assign flagVec = flags;

   cpu_status_flag_logic uut (.core_clk(core_clk), .nrst(nrst), .clkEn(clkEn), .execValid(execValid),
      .execReq(execReq), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .regRdata(regRdata), .flags(flags), .result(result), .quickReturn(quickReturn), .irqBlocked(irqBlocked));

   always #5 core_clk = ~core_clk;

   // A hung handshake would otherwise stall the run forever, so the cycle count is capped.
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         giveVerdict();
      end
   end

   task automatic giveVerdict();
      $display("Comparisons %0d, mismatches %0d.", nCompared, errors);
      if (errors == 0 && nCompared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   function automatic void add(input cpu_status_flag_pkg::op_t op,
      input logic [7:0] pre, dst, src, expF, maskF, expR, maskR);
      rows.push_back('{op, pre, dst, src, expF, maskF, expR, maskR});
   endfunction

   task automatic writeReg(input logic [3:0] a, input logic [7:0] v);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= v;
      regWrite <= 1'h1;
      @(posedge core_clk);
      regWrite <= 1'h0;
   endtask

   task automatic readReg(input logic [3:0] a, output logic [7:0] v);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'h1;
      @(posedge core_clk);
      regRead <= 1'h0;
      #1;
      v = regRdata;
   endtask

   task automatic execOp(input cpu_status_flag_pkg::op_t op, input logic [7:0] dst, input logic [7:0] src);
      @(posedge core_clk);
      execReq <= '{op: op, dst: dst, src: src};
      execValid <= 1'h1;
      @(posedge core_clk);
      execValid <= 1'h0;
      #1;
   endtask

   // Decimal adjust works on the result and flags that the previous operation left behind.
   task automatic daCase(input cpu_status_flag_pkg::op_t op, input logic [7:0] a, b, expR);
      writeReg(cpu_status_flag_pkg::FLAGS_OFFSET, 8'h00);
      execOp(op, a, b);
      execOp(cpu_status_flag_pkg::OP_DEC_ADJ, result, 8'h00);
      `CHK("decimal adjust", expR, result)
   endtask

   initial
   begin
      add(cpu_status_flag_pkg::OP_ADD, 8'h01, 8'hff, 8'h01, 8'hc5, 8'hfd, 8'h00, 8'hff);
      add(cpu_status_flag_pkg::OP_ADD, 8'h00, 8'h7f, 8'h01, 8'h34, 8'hfd, 8'h80, 8'hff);
      add(cpu_status_flag_pkg::OP_SUB, 8'h00, 8'h00, 8'h01, 8'hac, 8'hfd, 8'hff, 8'hff);
      add(cpu_status_flag_pkg::OP_SUB, 8'h00, 8'h80, 8'h01, 8'h1c, 8'hfd, 8'h7f, 8'hff);
      add(cpu_status_flag_pkg::OP_ADC, 8'h80, 8'h00, 8'h00, 8'h00, 8'hfd, 8'h01, 8'hff);
      add(cpu_status_flag_pkg::OP_SBC, 8'h80, 8'h05, 8'h05, 8'hac, 8'hfd, 8'hff, 8'hff);
      add(cpu_status_flag_pkg::OP_CMP, 8'h00, 8'h05, 8'h05, 8'h40, 8'hf1, 8'h00, 8'h00);
      add(cpu_status_flag_pkg::OP_AND, 8'h90, 8'hf0, 8'h0f, 8'hc0, 8'hf1, 8'h00, 8'hff);
      add(cpu_status_flag_pkg::OP_OR, 8'h11, 8'h80, 8'h01, 8'h21, 8'hf1, 8'h81, 8'hff);
      add(cpu_status_flag_pkg::OP_XOR, 8'h30, 8'hff, 8'hff, 8'h40, 8'h71, 8'h00, 8'hff);
      add(cpu_status_flag_pkg::OP_COM, 8'h50, 8'h00, 8'h00, 8'h20, 8'h71, 8'hff, 8'hff);
      add(cpu_status_flag_pkg::OP_TEST, 8'h00, 8'h0f, 8'hf0, 8'h40, 8'h41, 8'h00, 8'h00);
      add(cpu_status_flag_pkg::OP_RL, 8'h00, 8'h81, 8'h00, 8'h80, 8'he1, 8'h03, 8'hff);
      add(cpu_status_flag_pkg::OP_RLC, 8'h00, 8'h80, 8'h00, 8'hc0, 8'he1, 8'h00, 8'hff);
      add(cpu_status_flag_pkg::OP_RR, 8'h00, 8'h01, 8'h00, 8'ha0, 8'he1, 8'h80, 8'hff);
      add(cpu_status_flag_pkg::OP_RRC, 8'h00, 8'h01, 8'h00, 8'hc0, 8'he1, 8'h00, 8'hff);
      add(cpu_status_flag_pkg::OP_SRA, 8'h00, 8'h81, 8'h00, 8'ha0, 8'he1, 8'hc0, 8'hff);
      add(cpu_status_flag_pkg::OP_INC, 8'h80, 8'h7f, 8'h00, 8'hb0, 8'hf1, 8'h80, 8'hff);
      add(cpu_status_flag_pkg::OP_DEC, 8'h00, 8'h01, 8'h00, 8'h40, 8'hf1, 8'h00, 8'hff);
      add(cpu_status_flag_pkg::OP_CARRY_ONE, 8'h7d, 8'h00, 8'h00, 8'hfd, 8'hff, 8'h00, 8'h00);
      add(cpu_status_flag_pkg::OP_CARRY_ZERO, 8'hfd, 8'h00, 8'h00, 8'h7d, 8'hff, 8'h00, 8'h00);
      add(cpu_status_flag_pkg::OP_CARRY_INV, 8'h45, 8'h00, 8'h00, 8'hc5, 8'hff, 8'h00, 8'h00);
      add(cpu_status_flag_pkg::OP_PAGE_ZERO, 8'hfd, 8'h00, 8'h00, 8'hfc, 8'hff, 8'h00, 8'h00);
      add(cpu_status_flag_pkg::OP_PAGE_ONE, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff, 8'h00, 8'h00);
      repeat (5) @(posedge core_clk);
      #1;
      `CHK("flags in reset", 8'h00, flagVec)
      `CHK("outputs in reset", 18'h00000, {result, quickReturn, irqBlocked, regRdata})
      @(posedge core_clk);
      nrst <= 1'h1;
      readReg(cpu_status_flag_pkg::CTRL_OFFSET, d);
      `CHK("ctrl reset", cpu_status_flag_pkg::CTRL_RESET, d)
      readReg(cpu_status_flag_pkg::FLAGS_OFFSET, d);
      `CHK("flags reset", cpu_status_flag_pkg::FLAGS_RESET, d)
      foreach (rows[i])
      begin
         writeReg(cpu_status_flag_pkg::FLAGS_OFFSET, rows[i].pre);
         execOp(rows[i].op, rows[i].dst, rows[i].src);
         `CHK($sformatf("flags row %0d", i), rows[i].expF & rows[i].maskF, flagVec & rows[i].maskF)
         `CHK($sformatf("result row %0d", i), rows[i].expR & rows[i].maskR, result & rows[i].maskR)
      end
      writeReg(cpu_status_flag_pkg::FLAGS_OFFSET, 8'ha9);
      writeReg(4'hf, 8'h00);
      readReg(cpu_status_flag_pkg::FLAGS_OFFSET, d);
      `CHK("direct write", 8'ha9, d)
      `CHK("flag port", 8'ha9, flagVec)
      readReg(4'hf, d);
      `CHK("unmapped read", 8'h00, d)
      readReg(cpu_status_flag_pkg::LAST_OP_OFFSET, d);
      `CHK("last op", 8'(cpu_status_flag_pkg::OP_PAGE_ONE), d)
      writeReg(cpu_status_flag_pkg::CTRL_OFFSET, 8'h5a);
      readReg(cpu_status_flag_pkg::CTRL_OFFSET, d);
      `CHK("ctrl write", 8'h5a, d)
      // Two operations on consecutive edges: the second must see the flags of the first.
      writeReg(cpu_status_flag_pkg::FLAGS_OFFSET, 8'h00);
      @(posedge core_clk);
      execReq <= '{op: cpu_status_flag_pkg::OP_ADD, dst: 8'hff, src: 8'h01};
      execValid <= 1'h1;
      @(posedge core_clk);
      execReq <= '{op: cpu_status_flag_pkg::OP_CARRY_INV, dst: 8'h00, src: 8'h00};
      @(posedge core_clk);
      execValid <= 1'h0;
      #1;
      `CHK("back to back", 8'h40, flagVec & 8'hf1)
      @(posedge core_clk);
      regAddr <= cpu_status_flag_pkg::FLAGS_OFFSET;
      regWdata <= 8'h55;
      regWrite <= 1'h1;
      execReq <= '{op: cpu_status_flag_pkg::OP_CARRY_ONE, dst: 8'h00, src: 8'h00};
      execValid <= 1'h1;
      @(posedge core_clk);
      regWrite <= 1'h0;
      execValid <= 1'h0;
      #1;
      `CHK("collision", 8'hc4, flagVec)
      writeReg(cpu_status_flag_pkg::FLAGS_OFFSET, 8'h00);
      @(posedge core_clk);
      clkEn <= 1'h0;
      execValid <= 1'h1;
      repeat (2) @(posedge core_clk);
      execValid <= 1'h0;
      clkEn <= 1'h1;
      #1;
      `CHK("clock enable low", 8'h00, flagVec)
      execOp(cpu_status_flag_pkg::OP_IRQ_RETURN, 8'h00, 8'h00);
      `CHK("plain return", 1'h0, quickReturn)
      execOp(cpu_status_flag_pkg::OP_QUICK_ENTER, 8'h00, 8'h00);
      `CHK("quick bit set", 1'h1, flagVec[cpu_status_flag_pkg::QUICK_POS])
      @(posedge core_clk);
      #1;
      `CHK("irq blocked", 1'h1, irqBlocked)
      // Touch the carry inside the handler so that the restore on return is visible.
      execOp(cpu_status_flag_pkg::OP_CARRY_ONE, 8'h00, 8'h00);
      execOp(cpu_status_flag_pkg::OP_IRQ_RETURN, 8'h00, 8'h00);
      `CHK("quick return", 1'h1, quickReturn)
      `CHK("flags restored", 8'h00, flagVec)
      `CHK("quick bit clear", 1'h0, flagVec[cpu_status_flag_pkg::QUICK_POS])
      @(posedge core_clk);
      #1;
      `CHK("return pulse and block", 2'h0, {quickReturn, irqBlocked})
      daCase(cpu_status_flag_pkg::OP_ADD, 8'h09, 8'h01, 8'h10);
      daCase(cpu_status_flag_pkg::OP_ADD, 8'h09, 8'h09, 8'h18);
      daCase(cpu_status_flag_pkg::OP_ADD, 8'h90, 8'h90, 8'h80);
      daCase(cpu_status_flag_pkg::OP_SUB, 8'h10, 8'h01, 8'h09);
      writeReg(cpu_status_flag_pkg::FLAGS_OFFSET, 8'ha9);
      @(posedge core_clk);
      nrst <= 1'h0;
      @(posedge core_clk);
      #1;
      `CHK("second reset", 8'h00, flagVec)
      @(posedge core_clk);
      nrst <= 1'h1;
      readReg(cpu_status_flag_pkg::FLAGS_OFFSET, d);
      `CHK("flags after second reset", cpu_status_flag_pkg::FLAGS_RESET, d)
      giveVerdict();
   end
endmodule
`default_nettype wire
